/* pmc_pkg.sv */
// Package for the power mode controller: register map, fields, modes, signal carriers
package pmc_pkg;

	// Wishbone word offsets (byte addresses)
	localparam logic [3:0] PMC_ADDR_PWR_CTRL_ZERO = 4'h0;
	localparam logic [3:0] PMC_ADDR_PWR_CTRL_ONE = 4'h4;
	localparam logic [3:0] PMC_ADDR_REG_CTRL = 4'h8;
	localparam logic [3:0] PMC_ADDR_CLK_CTRL = 4'hc;

	// power_control_zero fields
	localparam int PMC_BIT_IDLE = 0;
	localparam int PMC_BIT_PDOWN = 1;
	// power_control_one fields
	localparam int PMC_BIT_FASTSLP = 0;
	localparam int PMC_BIT_LOWSLP = 1;
	// regulator_control fields
	localparam int PMC_BIT_REGOFF = 0;
	localparam int PMC_BIT_VREG5_EN = 1;
	// clock control fields
	localparam int PMC_BIT_SYSTEM_CLOCK_SEL = 0;
	localparam int PMC_BIT_LFCLK_T3 = 1;
	localparam int PMC_BIT_LFCLK_T4 = 2;

	// Reset values
	localparam logic [7:0] PMC_RST_REG_CTRL = 8'h02;
	localparam logic [7:0] PMC_RST_CLK_CTRL = 8'h00;

	// Number of gated peripheral clocks
	localparam int PMC_NUM_PERIPH = 8;
	// Low-frequency oscillator prescale for timers 3 and 4
	localparam int PMC_LF_DIV = 8;
	localparam int PMC_LF_DIV_W = 3;
	localparam logic [PMC_LF_DIV_W-1:0] PMC_LF_DIV_LAST = 3'h7;

	// Controller modes
	typedef enum logic [2:0]
	{
		PMC_MODE_NORMAL = 3'b000,
		PMC_MODE_IDLE = 3'b001,
		PMC_MODE_FASTSLP = 3'b010,
		PMC_MODE_LOWSLP = 3'b011,
		PMC_MODE_STOP = 3'b100,
		PMC_MODE_SHUTDOWN = 3'b101
	} pmc_mode_t;

	// Wake sources from peripherals
	typedef struct packed
	{
		logic usb_activity;
		logic timer4_event;
		logic spi_activity;
		logic i2c_slave_activity;
		logic port_match;
		logic cmp0_level;
	} pmc_wake_t;

	// Power controls towards the analog domain
	typedef struct packed
	{
		logic core_clk_en;
		logic hfosc_a_en;
		logic hfosc_b_en;
		logic reg_low_bias;
		logic ldo_en;
		logic power_nets_en;
		logic vreg5_en;
		logic pin_hold;
	} pmc_pwr_t;

	// Wishbone request carrier
	typedef struct packed
	{
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} pmc_wb_req_t;

endpackage : pmc_pkg

/* pmc_lf_prescaler.sv */
// Divide-by-eight tick generator for timers clocked from the low-frequency oscillator
module pmc_lf_prescaler
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic lf_tick_i,
	output logic tick_o
);

	typedef struct packed
	{
		logic [PMC_LF_DIV_W-1:0] cnt;
		logic tick;
	} pmc_pre_state_t;

	pmc_pre_state_t state_ff;
	pmc_pre_state_t nxt_state;

	// Count oscillator ticks, pulse on every eighth
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.tick = 1'b0;
		if (lf_tick_i)
		begin
			nxt_state.cnt = state_ff.cnt + 1'b1;
			nxt_state.tick = (state_ff.cnt == PMC_LF_DIV_LAST);
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign tick_o = state_ff.tick;

endmodule : pmc_lf_prescaler

/* pmc_power_mode_controller.sv */
// Power mode controller: mode sequencing, clock gating, regulator control, Wishbone slave
module pmc_power_mode_controller
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic irq_any_i,
	input wire pmc_wake_t wake_i,
	input wire logic reset_pin_n_i,
	input wire logic por_i,
	input wire logic other_reset_i,
	input wire logic lf_tick_i,
	input wire logic [PMC_NUM_PERIPH-1:0] periph_busy_i,
	output pmc_mode_t mode_o,
	output pmc_pwr_t pwr_o,
	output logic [PMC_NUM_PERIPH-1:0] periph_clk_en_o,
	output logic timer3_lf_tick_o,
	output logic timer4_lf_tick_o,
	output logic sysreset_req_o
);

	// All controller state in one carrier
	typedef struct packed
	{
		pmc_mode_t mode;
		logic idle_req;
		logic pdown_req;
		logic fastslp_req;
		logic lowslp_req;
		logic regoff_sel;
		logic vreg5_en;
		logic system_clock_sel;
		logic lf_t3;
		logic lf_t4;
		logic cmp0_prev;
		logic ack;
		logic [31:0] rdat;
		pmc_pwr_t pwr;
		logic [PMC_NUM_PERIPH-1:0] clk_en;
		logic reset_req;
	} pmc_state_t;

	pmc_state_t state_ff;
	pmc_state_t nxt_state;

	logic lf_div_tick;
	logic wb_access;
	logic wb_write;
	logic sleep_wake;
	logic cmp0_fall;
	logic stop_exit;
	logic shutdown_exit;
	logic [7:0] wdata;

	// Divided slow-oscillator tick for timers 3 and 4
	pmc_lf_prescaler u_lf_prescaler
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.lf_tick_i(lf_tick_i),
		.tick_o(lf_div_tick)
	);

	// Bus decode and wake event terms
	assign wb_access = wb_cyc_i & wb_stb_i & ~state_ff.ack;
	assign wb_write = wb_access & wb_we_i & wb_sel_i[0];
	assign wdata = wb_dat_i[7:0];
	assign cmp0_fall = state_ff.cmp0_prev & ~wake_i.cmp0_level;
	assign sleep_wake = wake_i.usb_activity | wake_i.timer4_event | wake_i.spi_activity
		| wake_i.i2c_slave_activity | wake_i.port_match | cmp0_fall;
	assign stop_exit = ~reset_pin_n_i | por_i | other_reset_i;
	assign shutdown_exit = ~reset_pin_n_i | por_i;

	// Next-state logic
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.ack = wb_access;
		nxt_state.cmp0_prev = wake_i.cmp0_level;
		nxt_state.reset_req = 1'b0;

		// Register reads
		if (wb_access && !wb_we_i)
		begin
			case (wb_adr_i)
				PMC_ADDR_PWR_CTRL_ZERO:
					nxt_state.rdat = {30'h0, state_ff.pdown_req, state_ff.idle_req};
				PMC_ADDR_PWR_CTRL_ONE:
					nxt_state.rdat = {30'h0, state_ff.lowslp_req, state_ff.fastslp_req};
				PMC_ADDR_REG_CTRL:
					nxt_state.rdat = {30'h0, state_ff.vreg5_en, state_ff.regoff_sel};
				PMC_ADDR_CLK_CTRL:
					nxt_state.rdat = {29'h0, state_ff.lf_t4, state_ff.lf_t3, state_ff.system_clock_sel};
				default:
					nxt_state.rdat = 32'h0;
			endcase
		end

		// Register writes (only taken while running in normal mode)
		if (wb_write && state_ff.mode == PMC_MODE_NORMAL)
		begin
			case (wb_adr_i)
				PMC_ADDR_PWR_CTRL_ZERO:
				begin
					nxt_state.idle_req = wdata[PMC_BIT_IDLE];
					nxt_state.pdown_req = wdata[PMC_BIT_PDOWN];
				end
				PMC_ADDR_PWR_CTRL_ONE:
				begin
					nxt_state.fastslp_req = wdata[PMC_BIT_FASTSLP];
					nxt_state.lowslp_req = wdata[PMC_BIT_LOWSLP];
				end
				PMC_ADDR_REG_CTRL:
				begin
					nxt_state.regoff_sel = wdata[PMC_BIT_REGOFF];
					nxt_state.vreg5_en = wdata[PMC_BIT_VREG5_EN];
				end
				PMC_ADDR_CLK_CTRL:
				begin
					nxt_state.system_clock_sel = wdata[PMC_BIT_SYSTEM_CLOCK_SEL];
					nxt_state.lf_t3 = wdata[PMC_BIT_LFCLK_T3];
					nxt_state.lf_t4 = wdata[PMC_BIT_LFCLK_T4];
				end
				default:
				begin
				end
			endcase
		end

		// Mode sequencing
		case (state_ff.mode)
			PMC_MODE_NORMAL:
			begin
				// Power-down wins over sleep, sleep over idle
				if (state_ff.pdown_req)
					nxt_state.mode = state_ff.regoff_sel ? PMC_MODE_SHUTDOWN : PMC_MODE_STOP;
				else if (state_ff.lowslp_req)
					nxt_state.mode = PMC_MODE_LOWSLP;
				else if (state_ff.fastslp_req)
					nxt_state.mode = PMC_MODE_FASTSLP;
				else if (state_ff.idle_req)
					nxt_state.mode = PMC_MODE_IDLE;
			end
			PMC_MODE_IDLE:
			begin
				if (irq_any_i)
				begin
					nxt_state.mode = PMC_MODE_NORMAL;
					nxt_state.idle_req = 1'b0;
				end
			end
			PMC_MODE_FASTSLP, PMC_MODE_LOWSLP:
			begin
				if (sleep_wake)
				begin
					nxt_state.mode = PMC_MODE_NORMAL;
					nxt_state.fastslp_req = 1'b0;
					nxt_state.lowslp_req = 1'b0;
				end
			end
			PMC_MODE_STOP:
			begin
				if (stop_exit)
				begin
					nxt_state.mode = PMC_MODE_NORMAL;
					nxt_state.reset_req = 1'b1;
				end
			end
			PMC_MODE_SHUTDOWN:
			begin
				if (shutdown_exit)
				begin
					nxt_state.mode = PMC_MODE_NORMAL;
					nxt_state.reset_req = 1'b1;
				end
			end
			default:
				nxt_state.mode = PMC_MODE_NORMAL;
		endcase

		// A reset out of power-down returns control state to defaults
		if (nxt_state.reset_req)
		begin
			nxt_state.idle_req = 1'b0;
			nxt_state.pdown_req = 1'b0;
			nxt_state.fastslp_req = 1'b0;
			nxt_state.lowslp_req = 1'b0;
			nxt_state.regoff_sel = PMC_RST_REG_CTRL[PMC_BIT_REGOFF];
			nxt_state.vreg5_en = PMC_RST_REG_CTRL[PMC_BIT_VREG5_EN];
			nxt_state.system_clock_sel = PMC_RST_CLK_CTRL[PMC_BIT_SYSTEM_CLOCK_SEL];
			nxt_state.lf_t3 = PMC_RST_CLK_CTRL[PMC_BIT_LFCLK_T3];
			nxt_state.lf_t4 = PMC_RST_CLK_CTRL[PMC_BIT_LFCLK_T4];
		end

		// Power controls per mode, taken from the mode about to be entered
		// 5V regulator follows its enable in every mode, power-down included
		nxt_state.pwr.vreg5_en = nxt_state.vreg5_en;
		case (nxt_state.mode)
			// Running: everything powered and clocked
			PMC_MODE_NORMAL:
			begin
				nxt_state.pwr.core_clk_en = 1'b1;
				nxt_state.pwr.hfosc_a_en = 1'b1;
				nxt_state.pwr.hfosc_b_en = 1'b1;
				nxt_state.pwr.reg_low_bias = 1'b0;
				nxt_state.pwr.ldo_en = 1'b1;
				nxt_state.pwr.power_nets_en = 1'b1;
				nxt_state.pwr.pin_hold = 1'b0;
			end
			// Core halted, peripherals keep their clocks
			PMC_MODE_IDLE:
			begin
				nxt_state.pwr.core_clk_en = 1'b0;
				nxt_state.pwr.hfosc_a_en = 1'b1;
				nxt_state.pwr.hfosc_b_en = 1'b1;
				nxt_state.pwr.reg_low_bias = 1'b0;
				nxt_state.pwr.ldo_en = 1'b1;
				nxt_state.pwr.power_nets_en = 1'b1;
				nxt_state.pwr.pin_hold = 1'b0;
			end
			// Fast-wake sleep: oscillators off, regulator at normal bias
			PMC_MODE_FASTSLP:
			begin
				nxt_state.pwr.core_clk_en = 1'b0;
				nxt_state.pwr.hfosc_a_en = 1'b0;
				nxt_state.pwr.hfosc_b_en = 1'b0;
				nxt_state.pwr.reg_low_bias = 1'b0;
				nxt_state.pwr.ldo_en = 1'b1;
				nxt_state.pwr.power_nets_en = 1'b1;
				nxt_state.pwr.pin_hold = 1'b0;
			end
			// Low-bias sleep: oscillators off, regulator in low bias
			PMC_MODE_LOWSLP:
			begin
				nxt_state.pwr.core_clk_en = 1'b0;
				nxt_state.pwr.hfosc_a_en = 1'b0;
				nxt_state.pwr.hfosc_b_en = 1'b0;
				nxt_state.pwr.reg_low_bias = 1'b1;
				nxt_state.pwr.ldo_en = 1'b1;
				nxt_state.pwr.power_nets_en = 1'b1;
				nxt_state.pwr.pin_hold = 1'b0;
			end
			// Stop: power nets down, LDO kept on, pins frozen
			PMC_MODE_STOP:
			begin
				nxt_state.pwr.core_clk_en = 1'b0;
				nxt_state.pwr.hfosc_a_en = 1'b0;
				nxt_state.pwr.hfosc_b_en = 1'b0;
				nxt_state.pwr.reg_low_bias = 1'b0;
				nxt_state.pwr.ldo_en = 1'b1;
				nxt_state.pwr.power_nets_en = 1'b0;
				nxt_state.pwr.pin_hold = 1'b1;
			end
			// Shutdown: LDO off as well, pins frozen
			PMC_MODE_SHUTDOWN:
			begin
				nxt_state.pwr.core_clk_en = 1'b0;
				nxt_state.pwr.hfosc_a_en = 1'b0;
				nxt_state.pwr.hfosc_b_en = 1'b0;
				nxt_state.pwr.reg_low_bias = 1'b0;
				nxt_state.pwr.ldo_en = 1'b0;
				nxt_state.pwr.power_nets_en = 1'b0;
				nxt_state.pwr.pin_hold = 1'b1;
			end
			// Unused codes: fall back to full power, as in normal mode
			default:
			begin
				nxt_state.pwr.core_clk_en = 1'b1;
				nxt_state.pwr.hfosc_a_en = 1'b1;
				nxt_state.pwr.hfosc_b_en = 1'b1;
				nxt_state.pwr.reg_low_bias = 1'b0;
				nxt_state.pwr.ldo_en = 1'b1;
				nxt_state.pwr.power_nets_en = 1'b1;
				nxt_state.pwr.pin_hold = 1'b0;
			end
		endcase

		// Peripheral clocks: on only while awake and in use
		if (nxt_state.mode == PMC_MODE_NORMAL || nxt_state.mode == PMC_MODE_IDLE)
			nxt_state.clk_en = periph_busy_i;
		else
			nxt_state.clk_en = '0;
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= '0;
			state_ff.mode <= PMC_MODE_NORMAL;
			state_ff.regoff_sel <= PMC_RST_REG_CTRL[PMC_BIT_REGOFF];
			state_ff.vreg5_en <= PMC_RST_REG_CTRL[PMC_BIT_VREG5_EN];
			state_ff.cmp0_prev <= 1'b1;
			state_ff.pwr <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		end
		else
			state_ff <= nxt_state;
	end

	// Outputs
	assign wb_ack_o = state_ff.ack;
	assign wb_dat_o = state_ff.rdat;
	assign mode_o = state_ff.mode;
	assign pwr_o = state_ff.pwr;
	assign periph_clk_en_o = state_ff.clk_en;
	assign sysreset_req_o = state_ff.reset_req;
	// Slow tick runs in active and sleep modes only
	assign timer3_lf_tick_o = lf_div_tick & state_ff.lf_t3 & state_ff.pwr.power_nets_en;
	assign timer4_lf_tick_o = lf_div_tick & state_ff.lf_t4 & state_ff.pwr.power_nets_en;

endmodule : pmc_power_mode_controller

/* pmc_event_model.sv */
// Peripheral model: wake, interrupt, reset events and slow oscillator ticks
module pmc_event_model
	import pmc_pkg::*;
(
	input wire logic clk_i,
	output pmc_wake_t wake_o,
	output logic irq_o,
	output logic reset_pin_n_o,
	output logic por_o,
	output logic other_reset_o,
	output logic lf_tick_o
);
	logic [9:0] ev_ff = 10'h000;
	logic [1:0] div_ff = 2'h0;
	// Idle levels: comparator output high, reset pin high
	assign {other_reset_o, por_o, reset_pin_n_o, irq_o, wake_o} = ev_ff ^ 10'h081;
	// Slow oscillator tick every fourth system clock
	always_ff @(posedge clk_i)
	begin
		div_ff <= div_ff + 2'h1;
	end
	assign lf_tick_o = (div_ff == 2'h3);
	// One-cycle event on one source, comparator as a falling edge
	task automatic fire(input int idx);
		@(posedge clk_i);
		ev_ff <= 10'h001 << idx;
		@(posedge clk_i);
		ev_ff <= 10'h000;
	endtask : fire
endmodule : pmc_event_model

/* pmc_asserts.sv */
// Concurrent checks on the power mode controller ports
module pmc_asserts
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire pmc_wake_t wake_i,
	input wire logic reset_pin_n_i,
	input wire logic por_i,
	input wire logic other_reset_i,
	input wire logic [PMC_NUM_PERIPH-1:0] periph_busy_i,
	input wire pmc_mode_t mode_o,
	input wire pmc_pwr_t pwr_o,
	input wire logic [PMC_NUM_PERIPH-1:0] periph_clk_en_o,
	input wire logic sysreset_req_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Bus answer timing
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	// Power controls per mode
	chk_idle_core: assert property (mode_o == PMC_MODE_IDLE |->
		!pwr_o.core_clk_en && pwr_o.power_nets_en) else $error("idle power wrong");
	chk_sleep_pwr: assert property (mode_o inside {PMC_MODE_FASTSLP, PMC_MODE_LOWSLP} |->
		!pwr_o.core_clk_en && !pwr_o.hfosc_a_en && !pwr_o.hfosc_b_en
		&& (pwr_o.reg_low_bias == (mode_o == PMC_MODE_LOWSLP))) else $error("sleep power wrong");
	chk_stop_pwr: assert property (mode_o == PMC_MODE_STOP |->
		pwr_o.ldo_en && !pwr_o.power_nets_en && pwr_o.pin_hold) else $error("stop power wrong");
	chk_shut_pwr: assert property (mode_o == PMC_MODE_SHUTDOWN |->
		!pwr_o.ldo_en && !pwr_o.power_nets_en && pwr_o.pin_hold) else $error("shutdown power wrong");
	// Mode exits
	chk_sleep_wake: assert property (mode_o inside {PMC_MODE_FASTSLP, PMC_MODE_LOWSLP}
		&& wake_i.spi_activity |=> mode_o == PMC_MODE_NORMAL) else $error("sleep not left");
	chk_shut_stay: assert property (mode_o == PMC_MODE_SHUTDOWN && reset_pin_n_i && !por_i
		|=> mode_o == PMC_MODE_SHUTDOWN) else $error("shutdown left early");
	chk_stop_exit: assert property (mode_o == PMC_MODE_STOP && other_reset_i |=>
		mode_o == PMC_MODE_NORMAL ##[0:1] sysreset_req_o) else $error("stop not left");
	// Clock gates follow peripheral use
	chk_gate_busy: assert property (mode_o == PMC_MODE_NORMAL && !$past(rst_i)
		&& $past(mode_o) == PMC_MODE_NORMAL |-> periph_clk_en_o == $past(periph_busy_i))
		else $error("gate wrong");
endmodule : pmc_asserts

bind pmc_power_mode_controller pmc_asserts pmc_asserts_i (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .wake_i, .reset_pin_n_i, .por_i, .other_reset_i, .periph_busy_i,
	.mode_o, .pwr_o, .periph_clk_en_o, .sysreset_req_o);

/* tb_power_mode_controller.sv */
// Self-checking bench for the power mode controller
module tb_power_mode_controller
	import pmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [3:0] adr; logic [1:0] dat; pmc_mode_t md;
		logic [3:0] hi; logic [3:0] src;} pmc_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	pmc_wb_req_t wb = '0;
	logic [7:0] busy = 8'h00;
	logic [31:0] rdat, rd;
	logic [7:0] clk_en;
	logic ack, irq, pin_n, por, oth, lft, t3, t4, srq;
	pmc_wake_t wake;
	pmc_mode_t mode;
	pmc_pwr_t pwr;
	int err_total = 0;
	int checks_done = 0;
	int n3, n4;
	// Request, expected mode and upper power bits (clocks, low bias), wake source
	pmc_row_t rows [7] = '{
		'{4'h0, 2'h1, PMC_MODE_IDLE, 4'h6, 4'h6},
		'{4'h4, 2'h1, PMC_MODE_FASTSLP, 4'h0, 4'h5},
		'{4'h4, 2'h2, PMC_MODE_LOWSLP, 4'h1, 4'h4},
		'{4'h4, 2'h1, PMC_MODE_FASTSLP, 4'h0, 4'h3},
		'{4'h4, 2'h2, PMC_MODE_LOWSLP, 4'h1, 4'h2},
		'{4'h4, 2'h1, PMC_MODE_FASTSLP, 4'h0, 4'h1},
		'{4'h4, 2'h2, PMC_MODE_LOWSLP, 4'h1, 4'h0}};
	always #2.5 clk_i = ~clk_i;
	pmc_power_mode_controller pmc_power_mode_controller_i (.clk_i, .rst_i,
		.wb_cyc_i(wb.cyc), .wb_stb_i(wb.stb), .wb_we_i(wb.we), .wb_adr_i(wb.adr),
		.wb_sel_i(wb.sel), .wb_dat_i(wb.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq_any_i(irq), .wake_i(wake), .reset_pin_n_i(pin_n), .por_i(por),
		.other_reset_i(oth), .lf_tick_i(lft), .periph_busy_i(busy), .mode_o(mode),
		.pwr_o(pwr), .periph_clk_en_o(clk_en), .timer3_lf_tick_o(t3),
		.timer4_lf_tick_o(t4), .sysreset_req_o(srq));
	pmc_event_model pmc_event_model_i (.clk_i, .wake_o(wake), .irq_o(irq),
		.reset_pin_n_o(pin_n), .por_o(por), .other_reset_o(oth), .lf_tick_o(lft));
	// Verdict and end of run
	task automatic tally_and_finish();
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// Compare one value
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Settle after n edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	// Classic single Wishbone cycle, lane 0
	task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb <= '{1'b1, 1'b1, we, adr, 4'h1, dat};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (!ack && n < 50);
		q = rdat;
		wb <= '0;
		if (!ack)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask : bus
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(1);
		check("rst", {mode, pwr}, {PMC_MODE_NORMAL, 8'hee});
		bus(1'b1, PMC_ADDR_CLK_CTRL, 32'h6, rd);
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].adr, {30'h0, rows[i].dat}, rd);
			tick(1);
			check("mode", mode, rows[i].md);
			check("pwr", pwr[7:4], rows[i].hi);
			pmc_event_model_i.fire(rows[i].src);
			tick(1);
			check("wake", mode, PMC_MODE_NORMAL);
			bus(1'b0, rows[i].adr, 32'h0, rd);
			check("req", rd, 32'h0);
		end
		@(posedge clk_i);
		busy <= 8'ha5;
		tick(2);
		check("gate", clk_en, 8'ha5);
		bus(1'b1, PMC_ADDR_PWR_CTRL_ONE, 32'h2, rd);
		tick(1);
		check("sgate", clk_en, 8'h00);
		n3 = 0;
		n4 = 0;
		repeat (256)
		begin
			@(posedge clk_i);
			n3 += t3;
			n4 += t4;
		end
		check("t3", n3, 8);
		check("t4", n4, 8);
		pmc_event_model_i.fire(4);
		tick(1);
		bus(1'b1, PMC_ADDR_REG_CTRL, 32'h2, rd);
		bus(1'b1, PMC_ADDR_PWR_CTRL_ZERO, 32'h2, rd);
		tick(1);
		check("stop", {mode, pwr[3:0]}, {PMC_MODE_STOP, 4'hb});
		pmc_event_model_i.fire(9);
		tick(1);
		check("exit", mode, PMC_MODE_NORMAL);
		// Shutdown left by pin reset, then by power-on reset
		for (int k = 7; k < 9; k++)
		begin
			bus(1'b1, PMC_ADDR_REG_CTRL, {30'h0, k == 7, 1'b1}, rd);
			bus(1'b1, PMC_ADDR_PWR_CTRL_ZERO, 32'h2, rd);
			tick(1);
			check("shut", {mode, pwr[3:0]}, {PMC_MODE_SHUTDOWN, 2'h0, k == 7, 1'b1});
			pmc_event_model_i.fire(9);
			tick(1);
			check("hold", mode, PMC_MODE_SHUTDOWN);
			pmc_event_model_i.fire(k);
			tick(1);
			check("out", mode, PMC_MODE_NORMAL);
		end
		bus(1'b0, PMC_ADDR_REG_CTRL, 32'h0, rd);
		check("regrst", rd, {24'h0, PMC_RST_REG_CTRL});
		bus(1'b0, 4'h2, 32'h0, rd);
		check("unmap", rd, 32'h0);
		tally_and_finish();
	end
endmodule : tb_power_mode_controller
